// ==== bench/tb_uif_ctrl.sv ====
// Purpose: Self-checking bench for uif_ctrl
// Assumes: 16-deep FIFOs; status inputs need up to three cycles to pass synchronisers
// Notes:   Consumer-IR is entered last, so line format is never written there
module tb_uif_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0, rst_b = 1'b1, rx_holding_full = 1'b0, tx_holding_empty = 1'b0, rx_timeout = 1'b0;
  logic       bottom_error = 1'b0, front_error = 1'b0, rx_overrun = 1'b0, tx_underrun = 1'b0, line_ack = 1'b0;
  logic       dma_tc = 1'b0, tx_bit = 1'b1, ir_pulse = 1'b0, ir_modulation = 1'b0;
  logic [5:0] rx_fifo_level = 6'h00, tx_fifo_level = 6'h00;
  logic [3:0] modem_status_reg = 4'h0, reg_addr, char_bits;
  logic [7:0] line_status_reg = 8'h00, reg_wdata, reg_rdata, v;
  logic       reg_write, reg_read, fifo_enable, rx_soft_reset, tx_soft_reset, parity_on;
  logic       serial_output, ir_transmit_output, irq;
  logic [1:0] stop_halves, parity_kind;
  logic [2:0] bank;
  int         num_errors = 0, total_checks = 0;
  always #5 clock = ~clock;
  uif_host host (.*);
  uif_ctrl #(.FIFO_DEPTH(16)) DUT (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wt;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask
  task lfw(input logic [7:0] d, e);
    host.wr(uif_pkg::OFS_LINE_BANK, d);
    wt;
    chk({char_bits, parity_kind, stop_halves}, e);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_format;
    rdc(uif_pkg::OFS_LINE_BANK, 8'h00);
    lfw(8'h1b, 8'h86);
    lfw(8'he4, 8'h86);
    chk({5'h00, bank}, 8'h03);
    rdc(uif_pkg::OFS_LINE_BANK, 8'he4);
    rdc(uif_pkg::OFS_SHADOW, 8'h1b);
    lfw(8'h84, 8'h53);
    lfw(8'hc1, 8'h62);
    chk({5'h00, bank}, 8'h01);
    for (int k = 0; k < 4; k++)
      lfw({2'h0, k[1:0], 4'hb}, {4'h8, k[1:0], 2'h2});
    chk({4'h0, parity_on, bank}, 8'h08);
    $display("format test done");
  endtask
  task t_events;
    @(posedge clock);
    rx_holding_full <= 1'b1;
    modem_status_reg <= 4'h1;
    line_status_reg <= 8'h40;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h29);
    host.wr(uif_pkg::OFS_EXT_CTRL, 8'h01);
    host.wr(uif_pkg::OFS_FIFO_CTRL, 8'hd1);
    @(posedge clock);
    rx_holding_full <= 1'b0;
    modem_status_reg <= 4'h0;
    line_status_reg <= 8'h00;
    rx_fifo_level <= 6'h0e;
    tx_fifo_level <= 6'h02;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h03);
    @(posedge clock);
    rx_fifo_level <= 6'h0d;
    tx_fifo_level <= 6'h03;
    modem_status_reg <= 4'h1;
    host.wr(uif_pkg::OFS_EXT_CTRL, 8'h03);
    host.wr(uif_pkg::OFS_MODE_CTRL, 8'h60);
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h00);
    host.wr(uif_pkg::OFS_MODE_CTRL, 8'h00);
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h08);
    modem_status_reg <= 4'h0;
    $display("event test done");
  endtask
  task t_line;
    @(posedge clock);
    bottom_error <= 1'b1;
    @(posedge clock);
    bottom_error <= 1'b0;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h04);
    @(posedge clock);
    line_ack <= 1'b1;
    @(posedge clock);
    line_ack <= 1'b0;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h00);
    @(posedge clock);
    rx_overrun <= 1'b1;
    @(posedge clock);
    rx_overrun <= 1'b0;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h04);
    @(posedge clock);
    line_ack <= 1'b1;
    dma_tc <= 1'b1;
    @(posedge clock);
    line_ack <= 1'b0;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h10);
    rdc(uif_pkg::OFS_EVENT, 8'h00);
    dma_tc <= 1'b0;
    $display("line test done");
  endtask
  task t_irq_break;
    @(posedge clock);
    line_status_reg <= 8'h40;
    host.wr(uif_pkg::OFS_INT_ENABLE, 8'h20);
    wt;
    chk({7'h00, irq}, 8'h01);
    host.wr(uif_pkg::OFS_INT_ENABLE, 8'h1f);
    wt;
    chk({7'h00, irq}, 8'h00);
    host.wr(uif_pkg::OFS_LINE_BANK, 8'h40);
    wt;
    chk({7'h00, serial_output}, 8'h00);
    host.wr(uif_pkg::OFS_MODE_CTRL, 8'h40);
    wt;
    chk({7'h00, ir_transmit_output}, 8'h01);
    host.wr(uif_pkg::OFS_MODE_CTRL, 8'h00);
    host.wr(uif_pkg::OFS_LINE_BANK, 8'h03);
    wt;
    chk({7'h00, serial_output}, 8'h01);
    $display("interrupt and break test done");
  endtask
  task t_fifo;
    host.wr(uif_pkg::OFS_FIFO_CTRL, 8'hc6);
    chk({6'h00, rx_soft_reset, tx_soft_reset}, 8'h03);
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h20);
    chk({7'h00, fifo_enable}, 8'h00);
    rdc(4'hf, 8'h00);
    host.wr(uif_pkg::OFS_MODE_CTRL, 8'hc0);
    wt;
    chk({7'h00, fifo_enable}, 8'h01);
    chk({char_bits, parity_kind, stop_halves}, 8'h52);
    @(posedge clock);
    tx_underrun <= 1'b1;
    @(posedge clock);
    tx_underrun <= 1'b0;
    wt;
    rdc(uif_pkg::OFS_EVENT, 8'h24);
    $display("fifo test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // A falling edge is needed to start the asynchronous reset
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    t_format;
    t_events;
    t_line;
    t_irq_break;
    t_fifo;
    report_and_stop;
  end
  initial
  begin
    #50000;
    num_errors++;
    report_and_stop;
  end
endmodule

// ==== bench/uif_ctrl_asserts.sv ====
// Purpose: Port checks on register decode and line format outputs
// Assumes: One clock, rst_b async active low
// Notes:   Mode is not visible at these ports, so mode rules stay in the bench
module uif_ctrl_asserts (
  input wire logic       clock,         // Clock
  input wire logic       rst_b,         // Reset
  input wire logic [3:0] reg_addr,      // Offset
  input wire logic [7:0] reg_wdata,     // Write data
  input wire logic       reg_write,     // Write strobe
  input wire logic       reg_read,      // Read strobe
  input wire logic [7:0] reg_rdata,     // Read data
  input wire logic       rx_soft_reset, // Rx reset pulse
  input wire logic       tx_soft_reset, // Tx reset pulse
  input wire logic [3:0] char_bits,     // Data bits
  input wire logic [1:0] stop_halves,   // Stop length
  input wire logic       parity_on,     // Parity on
  input wire logic [1:0] parity_kind,   // Parity kind
  input wire logic [2:0] bank           // Bank
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire w02 = reg_write && reg_addr == uif_pkg::OFS_FIFO_CTRL;
  wire w03 = reg_write && reg_addr == uif_pkg::OFS_LINE_BANK;
  wire lf  = w03 && !reg_wdata[7];
  wire b1  = w03 && reg_wdata[7] && (!reg_wdata[6] || reg_wdata[1:0] != 2'h0);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rx_sr; w02 && reg_wdata[1] |=> rx_soft_reset; endproperty
  a_rx_sr: assert property (p_rx_sr) else $error("rx soft reset missing");
  property p_tx_sr; tx_soft_reset |-> $past(w02 && reg_wdata[2]); endproperty
  a_tx_sr: assert property (p_tx_sr) else $error("tx soft reset without cause");
  // Decoded format outputs are one register behind the line format register
  property p_len; lf |-> ##2 char_bits == 4'h5 + {2'h0, $past(reg_wdata[1:0], 2)}; endproperty
  a_len: assert property (p_len) else $error("char length wrong");
  property p_stop;
    lf |-> ##2 stop_halves == (!$past(reg_wdata[2], 2) ? 2'h2 : ($past(reg_wdata[1:0], 2) == 2'h0 ? 2'h3 : 2'h0));
  endproperty
  a_stop: assert property (p_stop) else $error("stop length wrong");
  property p_par;
    lf |-> ##2 parity_on == $past(reg_wdata[3], 2) && parity_kind == $past(reg_wdata[5:4], 2);
  endproperty
  a_par: assert property (p_par) else $error("parity setting wrong");
  property p_bank0; lf |=> bank == 3'h0; endproperty
  a_bank0: assert property (p_bank0) else $error("bank not zero");
  property p_bank1; b1 |=> bank == 3'h1; endproperty
  a_bank1: assert property (p_bank1) else $error("bank one not chosen");
  property p_keep; w03 && reg_wdata[7] && !b1 |-> ##2 $stable(char_bits) && $stable(parity_kind); endproperty
  a_keep: assert property (p_keep) else $error("line format changed");
  property p_rsv; $past(reg_read && reg_addr == uif_pkg::OFS_EVENT) |-> reg_rdata[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("event top bits set");
endmodule

bind uif_ctrl uif_ctrl_asserts u_chk (.*);

// ==== bench/uif_host.sv ====
// Purpose: Host register master for the uif_ctrl bench
// Assumes: Each access starts just after a rising edge
// Notes:   One idle cycle between accesses keeps strobes single-assigned
module uif_host (
  input  wire logic       clock,     // Clock
  output logic      [3:0] reg_addr,  // Offset
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_write, // Write strobe
  output logic            reg_read,  // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Released data must not keep showing the last value
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ==== verilog/uif_ctrl.sv ====
// Purpose: Event flags, FIFO control and line format / bank select registers
// Assumes: Serial engines and FIFOs sit outside; their status arrives on inputs
// Notes:   Pin-derived status inputs pass two flip-flops before use
//
// Functional notes
// - Receive high flag: holding full, or FIFO at or above threshold or timeout.
// - Transmit low flag: holding empty, or FIFO below transmit threshold.
// - Line event flag on receiver error or break in UART, ASK-IR, SIR.
// - With FIFOs, parity/framing/break report at FIFO bottom; overrun at once.
// - Consumer-IR: bit 2 flags receiver overrun or transmitter underrun.
// - Modem flag from modem status bits 0-3; IR mode forced 0 if select set.
// - DMA flag sets on terminal count, clears when event register read.
// - Transmitter-idle flag mirrors line status bit 6 in UART, ASK-IR, CIR.
// - FIFO control at offset 02h is write-only; reads return events instead.
// - FIFO enable bit enables both FIFOs; clear flushes; always on in CIR.
// - Soft reset bits pulse receiver or transmitter reset, self clearing.
// - Transmit threshold from bits 5:4 in extended modes, ignored otherwise.
// - Receive threshold from bits 7:6; event when level at or above.
// - Reads at 03h return bank select; line format readable via shadow.
// - Write 03h: bit 7 clear updates both; else bank select only unless bank 1.
// - Bank decode: bit 7 set, bit 6 clear or low bits set gives bank 1.
// - Line format register resets to zero.
// - Line format bits 6:0 ignored in consumer-IR mode.
// - Character length 5, 6, 7 or 8 bits from bits 1:0.
// - Stop-count: one stop; set gives 1.5 for 5-bit else two; rx checks one.
// - Parity: odd, even, stick 1, stick 0 selected by even and stick bits.
// - Break forces serial low in UART, IR pulses in SIR, ASK-IR per modulation.
// - Event register bits 7:6 read zero and ignore writes.
module uif_ctrl #(
  parameter int FIFO_DEPTH = 16            // 16 or 32
) (
  input  wire logic        clock,            // 100 MHz
  input  wire logic        rst_b,            // Async reset, active low
  input  wire logic [3:0]  reg_addr,         // Register offset
  input  wire logic [7:0]  reg_wdata,        // Write data
  input  wire logic        reg_write,        // Write strobe
  input  wire logic        reg_read,         // Read strobe
  output logic      [7:0]  reg_rdata,        // Read data, cycle after strobe
  input  wire logic        rx_holding_full,  // Receive holding register full
  input  wire logic        tx_holding_empty, // Transmit holding register empty
  input  wire logic [5:0]  rx_fifo_level,    // Receive FIFO fill
  input  wire logic [5:0]  tx_fifo_level,    // Transmit FIFO fill
  input  wire logic        rx_timeout,       // Receive FIFO timeout level
  input  wire logic        bottom_error,     // Parity/frame/break at FIFO bottom
  input  wire logic        front_error,      // Parity/frame/break as received
  input  wire logic        rx_overrun,       // Overrun pulse
  input  wire logic        tx_underrun,      // Transmitter halted pulse
  input  wire logic        line_ack,         // Line status read pulse
  input  wire logic [3:0]  modem_status_reg, // Modem status change bits
  input  wire logic [7:0]  line_status_reg,  // Line status value
  input  wire logic        dma_tc,           // Terminal count, async pin
  input  wire logic        tx_bit,           // Transmit engine serial bit
  input  wire logic        ir_pulse,         // IR pulse source
  input  wire logic        ir_modulation,    // ASK-IR internal modulation on
  output logic             fifo_enable,      // FIFOs enabled
  output logic             rx_soft_reset,    // One-cycle receiver reset
  output logic             tx_soft_reset,    // One-cycle transmitter reset
  output logic      [3:0]  char_bits,        // Data bits per character
  output logic      [1:0]  stop_halves,      // Stop length in half bits
  output logic             parity_on,        // Parity generated and checked
  output logic      [1:0]  parity_kind,      // 0 odd,1 even,2 stick1,3 stick0
  output logic      [2:0]  bank,             // Selected bank
  output logic             serial_output,    // UART line out
  output logic             ir_transmit_output, // IR line out
  output logic             irq               // Interrupt request
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers and synchronisers
  logic [7:0] fifo_ctrl_q, line_format_q, bank_select_reg_q, int_enable_q, rdata_q;
  logic [2:0] mode_q;
  logic [1:0] ext_ctrl_q;
  logic       dma_done_flag_q, line_event_flag_q;
  logic       rst_rx_q, rst_tx_q;
  logic [1:0] tc_sync_q;
  logic       tc_last_q;
  logic       ser_q, irt_q, irq_q, fifo_en_q;
  logic [3:0] char_q;
  logic [1:0] stop_q, pk_q;
  logic       pen_q;
  logic [2:0] bank_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_fifo  = reg_write && reg_addr == uif_pkg::OFS_FIFO_CTRL;
  wire wr_line  = reg_write && reg_addr == uif_pkg::OFS_LINE_BANK;
  wire rd_event = reg_read  && reg_addr == uif_pkg::OFS_EVENT;
  wire extended = ext_ctrl_q[0];
  wire ir_modem_status_select = ext_ctrl_q[1];
  wire is_cir   = mode_q == uif_pkg::MODE_CIR;
  wire is_uart  = mode_q == uif_pkg::MODE_UART;
  wire is_sir   = mode_q == uif_pkg::MODE_SIR;
  wire is_ask   = mode_q == uif_pkg::MODE_ASKIR;
  wire fifo_on  = fifo_ctrl_q[uif_pkg::FC_ENABLE] || is_cir;

  // Bank decode of a value written with bit 7 set
  function automatic logic [2:0] bank_of(input logic [7:0] v);
    logic [2:0] b;
    b = 3'h0;
    if (!v[7])
      b = 3'h0;
    else if (!v[6] || v[1] || v[0])
      b = 3'h1;
    else if (v[5] && v[4:3] != 2'b11)
      b = 3'(3'h2 + v[4:2]);
    else
      b = 3'h0; // Reserved codes fall back to bank 0
    return b;
  endfunction
  wire [2:0] new_bank  = bank_of(reg_wdata);
  wire       lf_update = wr_line && (!reg_wdata[uif_pkg::LF_BANKEN] || new_bank == 3'h1);

  // Thresholds
  wire [1:0] txc = fifo_ctrl_q[uif_pkg::FC_TX_TH +: 2];
  wire [1:0] rxc = fifo_ctrl_q[uif_pkg::FC_RX_TH +: 2];
  wire [5:0] tx_th = !extended ? 6'h01 :
                     (FIFO_DEPTH == 32 ? uif_pkg::TX_TH32[txc] : uif_pkg::TX_TH16[txc]);
  wire [5:0] rx_th = FIFO_DEPTH == 32 ? uif_pkg::RX_TH32[rxc] : uif_pkg::RX_TH16[rxc];

  // Event flags
  wire rx_high_level_flag = fifo_on ? (rx_fifo_level >= rx_th || rx_timeout) : rx_holding_full;
  wire tx_low_level_flag  = fifo_on ? (tx_fifo_level < tx_th) : tx_holding_empty;
  wire rx_err   = fifo_on ? bottom_error : front_error;
  wire lev_set  = is_cir ? (rx_overrun || tx_underrun) : (rx_err || rx_overrun);
  wire modem_event_flag = (is_uart || !ir_modem_status_select) &&
                          |modem_status_reg[uif_pkg::MODEM_STATUS_BITS-1:0];
  wire tx_idle_flag = (is_uart || is_ask || is_cir) && line_status_reg[6];
  wire tc_rise  = tc_sync_q[1] && !tc_last_q;
  wire [7:0] event_ident = {2'b00, tx_idle_flag, dma_done_flag_q, modem_event_flag,
                            line_event_flag_q, tx_low_level_flag, rx_high_level_flag};

  // Read mux: offset 02h returns events, never FIFO control
  wire [7:0] rd_mux =
    reg_addr == uif_pkg::OFS_EVENT      ? event_ident :
    reg_addr == uif_pkg::OFS_LINE_BANK  ? bank_select_reg_q :
    reg_addr == uif_pkg::OFS_SHADOW && bank == 3'h3 ? line_format_q :
    reg_addr == uif_pkg::OFS_INT_ENABLE ? int_enable_q :
    reg_addr == uif_pkg::OFS_MODE_CTRL  ? {mode_q, 5'h00} :
    reg_addr == uif_pkg::OFS_EXT_CTRL   ? {6'h00, ext_ctrl_q} : 8'h00;

  // Line format decode; consumer-IR ignores bits 6:0
  wire [7:0] lf  = is_cir ? 8'h00 : line_format_q;
  wire [3:0] cb  = 4'(4'h5 + {2'b00, lf[1:0]});
  wire [1:0] sh  = !lf[2] ? 2'h2 : (lf[1:0] == 2'b00 ? 2'h3 : 2'h0); // 0 codes four halves
  wire       brk = lf[uif_pkg::LF_BREAK];
  wire ser_d = (brk && is_uart) ? 1'b0 : tx_bit;
  wire irt_d = !brk ? ir_pulse : is_sir ? ir_pulse : (is_ask && !ir_modulation) ? 1'b1 : ir_pulse;
  wire irq_d = |(event_ident[5:0] & int_enable_q[5:0]);

  ////////////////////////////////////////////////////////////////////////////
  // State
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fifo_ctrl_q       <= uif_pkg::RST_FIFO_CTRL;
      line_format_q     <= uif_pkg::RST_LINE_FORMAT;
      bank_select_reg_q <= uif_pkg::RST_BANK_SELECT;
      int_enable_q      <= uif_pkg::RST_INT_ENABLE;
      mode_q            <= uif_pkg::RST_MODE;
      ext_ctrl_q        <= uif_pkg::RST_EXT_CTRL;
      dma_done_flag_q   <= 1'b0;
      line_event_flag_q <= 1'b0;
      rst_rx_q          <= 1'b0;
      rst_tx_q          <= 1'b0;
      tc_sync_q         <= 2'b00;
      tc_last_q         <= 1'b0;
      rdata_q           <= 8'h00;
    end
    else
    begin
      tc_sync_q <= {tc_sync_q[0], dma_tc};
      tc_last_q <= tc_sync_q[1];
      rdata_q   <= reg_read ? rd_mux : 8'h00;
      if (wr_fifo)
        fifo_ctrl_q <= {reg_wdata[7:4], 1'b0, 2'b00, reg_wdata[0]};
      rst_rx_q <= wr_fifo && reg_wdata[uif_pkg::FC_RX_RST];
      rst_tx_q <= wr_fifo && reg_wdata[uif_pkg::FC_TX_RST];
      if (wr_line)
        bank_select_reg_q <= reg_wdata;
      if (lf_update)
        line_format_q <= reg_wdata;
      if (reg_write && reg_addr == uif_pkg::OFS_INT_ENABLE)
        int_enable_q <= {2'b00, reg_wdata[5:0]};
      if (reg_write && reg_addr == uif_pkg::OFS_MODE_CTRL)
        mode_q <= reg_wdata[7:5];
      if (reg_write && reg_addr == uif_pkg::OFS_EXT_CTRL)
        ext_ctrl_q <= reg_wdata[1:0];
      // Set wins over clear
      if (tc_rise)
        dma_done_flag_q <= 1'b1;
      else if (rd_event)
        dma_done_flag_q <= 1'b0;
      if (lev_set)
        line_event_flag_q <= 1'b1;
      else if (line_ack || rst_rx_q)
        line_event_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ser_q  <= 1'b1;
      irt_q  <= 1'b0;
      irq_q  <= 1'b0;
      fifo_en_q <= 1'b0;
      char_q <= 4'h5;
      stop_q <= 2'h2;
      pen_q  <= 1'b0;
      pk_q   <= 2'h0;
      bank_q <= 3'h0;
    end
    else
    begin
      ser_q  <= ser_d;
      irt_q  <= irt_d;
      irq_q  <= irq_d;
      fifo_en_q <= fifo_on;
      char_q <= cb;
      stop_q <= sh;
      pen_q  <= lf[3];
      pk_q   <= {lf[5], lf[5] ^ lf[4]} ^ {1'b0, lf[5]};
      bank_q <= lf_update && !reg_wdata[7] ? 3'h0 : wr_line ? new_bank : bank_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata          = rdata_q;
  assign fifo_enable        = fifo_en_q;
  assign rx_soft_reset      = rst_rx_q;
  assign tx_soft_reset      = rst_tx_q;
  assign char_bits          = char_q;
  assign stop_halves        = stop_q;
  assign parity_on          = pen_q;
  assign parity_kind        = pk_q;
  assign bank               = bank_q;
  assign serial_output      = ser_q;
  assign ir_transmit_output = irt_q;
  assign irq                = irq_q;
endmodule

// ==== verilog/uif_pkg.sv ====
// Purpose: Constants for the UART/IR event, FIFO control and line format block
// Assumes: 8-bit register port, one clock
// Notes:   Offsets are byte addresses on the plain register port
package uif_pkg;
  localparam logic [3:0] OFS_EVENT      = 4'h2;  // Read side of shared offset
  localparam logic [3:0] OFS_FIFO_CTRL  = 4'h2;  // Write side of shared offset
  localparam logic [3:0] OFS_LINE_BANK  = 4'h3;
  localparam logic [3:0] OFS_INT_ENABLE = 4'h1;
  localparam logic [3:0] OFS_MODE_CTRL  = 4'h4;
  localparam logic [3:0] OFS_SHADOW     = 4'h7;  // Line format shadow, bank 3
  localparam logic [3:0] OFS_EXT_CTRL   = 4'h8;  // Extended-mode and select bits

  localparam logic [7:0] RST_LINE_FORMAT = 8'h00;
  localparam logic [7:0] RST_BANK_SELECT = 8'h00;
  localparam logic [7:0] RST_FIFO_CTRL   = 8'h00;
  localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
  localparam logic [2:0] RST_MODE        = 3'h0;
  localparam logic [1:0] RST_EXT_CTRL    = 2'h0;

  localparam int FC_ENABLE = 0;
  localparam int FC_RX_RST = 1;
  localparam int FC_TX_RST = 2;
  localparam int FC_TX_TH  = 4;
  localparam int FC_RX_TH  = 6;
  localparam int LF_BREAK  = 6;
  localparam int LF_BANKEN = 7;
  localparam int MODEM_STATUS_BITS = 4;

  localparam logic [2:0] MODE_UART  = 3'h0;
  localparam logic [2:0] MODE_ASKIR = 3'h2;
  localparam logic [2:0] MODE_SIR   = 3'h3;
  localparam logic [2:0] MODE_CIR   = 3'h6;

  localparam logic [5:0] TX_TH16 [4] = '{6'h01, 6'h03, 6'h09, 6'h0d};
  localparam logic [5:0] TX_TH32 [4] = '{6'h01, 6'h07, 6'h11, 6'h19};
  localparam logic [5:0] RX_TH16 [4] = '{6'h01, 6'h04, 6'h08, 6'h0e};
  localparam logic [5:0] RX_TH32 [4] = '{6'h01, 6'h08, 6'h10, 6'h1a};
endpackage
